// File: common/fci_defs.svh
// Named constants for the flash command interface host controller.
// Assumes a 125 MHz core clock; all bus timings are derived from it.
`ifndef FCI_DEFS_SVH
`define FCI_DEFS_SVH

// ----------------------------------------------------------------
// Command codes (low byte of a command write)
// ----------------------------------------------------------------
`define FCI_CMD_READ_ARRAY   8'hff
`define FCI_CMD_READ_ID      8'h90
`define FCI_CMD_READ_QUERY   8'h98
`define FCI_CMD_READ_STATUS  8'h70
`define FCI_CMD_CLEAR_STATUS 8'h50
`define FCI_CMD_BUFFER_WRITE 8'he8
`define FCI_CMD_PROGRAM      8'h40
`define FCI_CMD_ERASE        8'h20
`define FCI_CMD_SUSPEND      8'hb0
`define FCI_CMD_CONFIRM      8'hd0
`define FCI_CMD_CONFIG       8'hb8
`define FCI_CMD_LOCK_SETUP   8'h60
`define FCI_CMD_SET_BLOCK    8'h01
`define FCI_CMD_SET_MASTER   8'hf1
`define FCI_CMD_UPPER        8'h00

// ----------------------------------------------------------------
// Status and extended buffer status fields
// ----------------------------------------------------------------
`define FCI_SR_READY_BIT     7
`define FCI_XSR_AVAIL_BIT    7
`define FCI_SR_ERR_MASK      8'h3a

// ----------------------------------------------------------------
// Timing, in ns and in core clock cycles
// ----------------------------------------------------------------
`define FCI_CLK_NS           8
`define FCI_T_SETUP_NS       10
`define FCI_T_WP_NS          70
`define FCI_T_HOLD_NS        30
`define FCI_T_ACC_NS         150
`define FCI_T_RP_NS          100
`define FCI_T_RECOVER_NS     1000
`define FCI_SETUP_CYC   (8'((`FCI_T_SETUP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS))
`define FCI_WP_CYC      (8'((`FCI_T_WP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS))
`define FCI_HOLD_CYC    (8'((`FCI_T_HOLD_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS))
`define FCI_ACC_CYC     (8'((`FCI_T_ACC_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS))
`define FCI_RP_CYC      (8'((`FCI_T_RP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS))
`define FCI_RECOVER_CYC (8'((`FCI_T_RECOVER_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS))
`define FCI_SYNC_CYC         8'h02

`endif

// File: common/fci_pkg.sv
// Types shared by the flash command interface host controller.
// Assumes fci_defs.svh supplies all numeric constants.
package fci_pkg;

  // ----------------------------------------------------------------
  // User operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FCI_OP_READ,
    FCI_OP_READ_ARRAY,
    FCI_OP_READ_ID,
    FCI_OP_READ_QUERY,
    FCI_OP_READ_STATUS,
    FCI_OP_CLEAR_STATUS,
    FCI_OP_BUFFER,
    FCI_OP_PROGRAM,
    FCI_OP_ERASE,
    FCI_OP_SUSPEND,
    FCI_OP_RESUME,
    FCI_OP_CONFIG,
    FCI_OP_SET_BLOCK_LOCK,
    FCI_OP_CLEAR_LOCKS,
    FCI_OP_SET_MASTER_LOCK
  } fci_op_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FCI_ST_RST_HOLD,
    FCI_ST_RST_WAIT,
    FCI_ST_IDLE,
    FCI_ST_CMD1,
    FCI_ST_CMD2,
    FCI_ST_READ,
    FCI_ST_XSR,
    FCI_ST_COUNT,
    FCI_ST_DATA,
    FCI_ST_CONFIRM,
    FCI_ST_POLL,
    FCI_ST_FINISH
  } fci_state_t;

endpackage

// File: logic/fci_bus_cycle.sv
// One asynchronous parallel bus cycle (read or write) on the flash pins.
// Assumes the caller pulses go only while idle and waits for done.
`timescale 1ns/1ns
`include "fci_defs.svh"

module fci_bus_cycle
  import fci_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Cycle request
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [22:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // Flash pins
  output logic [22:0]      flash_addr,
  output logic [15:0]      flash_dq_o,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_i,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);

  typedef enum logic [2:0] {B_IDLE, B_SETUP, B_STROBE, B_SAMPLE, B_HOLD} fci_bstate_t;

  fci_bstate_t bst_r, bst_nxt;
  logic        wr_r, wr_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        done_r, done_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [22:0] addr_r, addr_nxt;
  logic [15:0] dqo_r, dqo_nxt;
  logic        oe_r, oe_nxt;
  logic        ce_n_r, ce_n_nxt;
  logic        oen_r, oen_nxt;
  logic        wen_r, wen_nxt;
  logic [15:0] d1_r, d2_r, d3_r;

  // ----------------------------------------------------------------
  // Data bus synchroniser, three stages
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    d1_r <= flash_dq_i;
    d2_r <= d1_r;
    d3_r <= d2_r;
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    bst_nxt   = bst_r;
    wr_nxt    = wr_r;
    cnt_nxt   = cnt_r + 8'h01;
    done_nxt  = 1'b0;
    rdata_nxt = rdata_r;
    addr_nxt  = addr_r;
    dqo_nxt   = dqo_r;
    oe_nxt    = oe_r;
    ce_n_nxt  = ce_n_r;
    oen_nxt   = oen_r;
    wen_nxt   = wen_r;
    case (bst_r)
      B_IDLE:
      begin
        cnt_nxt = 8'h00;
        if (go)
        begin
          wr_nxt   = wr;
          addr_nxt = addr;
          dqo_nxt  = wdata;
          oe_nxt   = wr;
          ce_n_nxt = 1'b0;
          bst_nxt  = B_SETUP;
        end
      end
      B_SETUP:
        if (cnt_r == `FCI_SETUP_CYC - 8'h01)
        begin
          cnt_nxt = 8'h00;
          wen_nxt = ~wr_r;
          oen_nxt = wr_r;
          bst_nxt = B_STROBE;
        end
      B_STROBE:
        if (cnt_r == (wr_r ? `FCI_WP_CYC : `FCI_ACC_CYC) - 8'h01)
        begin
          cnt_nxt = 8'h00;
          // Flash latches address and data on this rising edge
          wen_nxt = 1'b1;
          bst_nxt = wr_r ? B_HOLD : B_SAMPLE;
        end
      B_SAMPLE:
        // Wait for the synchroniser to fill and settle
        if (cnt_r >= `FCI_SYNC_CYC && d2_r == d3_r)
        begin
          cnt_nxt   = 8'h00;
          rdata_nxt = d3_r;
          oen_nxt   = 1'b1;
          bst_nxt   = B_HOLD;
        end
      B_HOLD:
        if (cnt_r == `FCI_HOLD_CYC - 8'h01)
        begin
          ce_n_nxt = 1'b1;
          oe_nxt   = 1'b0;
          done_nxt = 1'b1;
          bst_nxt  = B_IDLE;
        end
      default:
        bst_nxt = B_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      bst_r   <= B_IDLE;
      wr_r    <= 1'b0;
      cnt_r   <= 8'h00;
      done_r  <= 1'b0;
      rdata_r <= 16'h0000;
      addr_r  <= 23'h000000;
      dqo_r   <= 16'h0000;
      oe_r    <= 1'b0;
      ce_n_r  <= 1'b1;
      oen_r   <= 1'b1;
      wen_r   <= 1'b1;
    end
    else
    begin
      bst_r   <= bst_nxt;
      wr_r    <= wr_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
      rdata_r <= rdata_nxt;
      addr_r  <= addr_nxt;
      dqo_r   <= dqo_nxt;
      oe_r    <= oe_nxt;
      ce_n_r  <= ce_n_nxt;
      oen_r   <= oen_nxt;
      wen_r   <= wen_nxt;
    end
  end

  assign done        = done_r;
  assign rdata       = rdata_r;
  assign flash_addr  = addr_r;
  assign flash_dq_o  = dqo_r;
  assign flash_dq_oe = oe_r;
  assign flash_ce_n  = ce_n_r;
  assign flash_oe_n  = oen_r;
  assign flash_we_n  = wen_r;

endmodule

// File: logic/fci_host.sv
// Host controller that drives a NOR flash command user interface.
// Assumes a single 125 MHz clock and the flash pins wired straight out.
`timescale 1ns/1ns
`include "fci_defs.svh"

module fci_host
  import fci_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // User command port
  input  wire logic        cmd_valid,
  input  wire fci_op_t     cmd_op,
  input  wire logic [22:0] cmd_addr,
  input  wire logic [15:0] cmd_data,
  input  wire logic [4:0]  cmd_count,
  input  wire logic        cmd_elevate,
  output logic             cmd_ready,
  output logic             done,
  output logic [15:0]      rd_data,
  output logic             status_err,
  output logic             sts_busy,
  // Buffered write data stream
  input  wire logic        buf_valid,
  input  wire logic [15:0] buf_data,
  output logic             buf_ready,
  // Flash pins
  output logic [22:0]      flash_addr,
  output logic [15:0]      flash_dq_o,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_i,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic             flash_rp_n,
  output logic             flash_rp_hh_en,
  output logic             flash_program_enable_supply_en,
  input  wire logic        flash_sts_i
);

  fci_state_t  st_r, st_nxt;
  fci_op_t     op_r, op_nxt;
  logic        pend_r, pend_nxt;
  logic        go_r, go_nxt;
  logic        bwr_r, bwr_nxt;
  logic [22:0] badr_r, badr_nxt;
  logic [15:0] bdat_r, bdat_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [4:0]  idx_r, idx_nxt;
  logic [22:0] addr_r, addr_nxt;
  logic [15:0] data_r, data_nxt;
  logic [4:0]  count_r, count_nxt;
  logic        ready_r, ready_nxt;
  logic        done_r, done_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic        err_r, err_nxt;
  logic        bufrdy_r, bufrdy_nxt;
  logic        rp_n_r, rp_n_nxt;
  logic        hh_r, hh_nxt;
  logic        program_enable_supply_r, program_enable_supply_nxt;
  logic        s1_r, s2_r, s3_r;
  logic        busy_r;
  logic        bus_done;
  logic [15:0] bus_rdata;
  logic        req;
  logic        req_wr;
  logic [22:0] req_adr;
  logic [15:0] req_dat;
  logic        fin;

  // ----------------------------------------------------------------
  // Command codes per operation
  // ----------------------------------------------------------------
  // Defined codes leave this table except program data and the config byte; upper byte zero except for program data
  function automatic logic [7:0] first_code(input fci_op_t op);
    case (op)
      FCI_OP_READ_ARRAY:   first_code = `FCI_CMD_READ_ARRAY;
      FCI_OP_READ_ID:      first_code = `FCI_CMD_READ_ID;
      FCI_OP_READ_QUERY:   first_code = `FCI_CMD_READ_QUERY;
      FCI_OP_READ_STATUS:  first_code = `FCI_CMD_READ_STATUS;
      FCI_OP_CLEAR_STATUS: first_code = `FCI_CMD_CLEAR_STATUS;
      FCI_OP_BUFFER:       first_code = `FCI_CMD_BUFFER_WRITE;
      FCI_OP_PROGRAM:      first_code = `FCI_CMD_PROGRAM;
      FCI_OP_ERASE:        first_code = `FCI_CMD_ERASE;
      FCI_OP_SUSPEND:      first_code = `FCI_CMD_SUSPEND;
      FCI_OP_RESUME:       first_code = `FCI_CMD_CONFIRM;
      FCI_OP_CONFIG:       first_code = `FCI_CMD_CONFIG;
      default:             first_code = `FCI_CMD_LOCK_SETUP;
    endcase
  endfunction

  function automatic logic [15:0] second_word(input fci_op_t op, input logic [15:0] d);
    case (op)
      FCI_OP_PROGRAM:         second_word = d;
      FCI_OP_CONFIG:          second_word = {`FCI_CMD_UPPER, d[7:0]};
      FCI_OP_ERASE:           second_word = {`FCI_CMD_UPPER, `FCI_CMD_CONFIRM};
      FCI_OP_SET_BLOCK_LOCK:  second_word = {`FCI_CMD_UPPER, `FCI_CMD_SET_BLOCK};
      FCI_OP_SET_MASTER_LOCK: second_word = {`FCI_CMD_UPPER, `FCI_CMD_SET_MASTER};
      default:                second_word = {`FCI_CMD_UPPER, `FCI_CMD_CONFIRM};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt     = st_r;
    op_nxt     = op_r;
    pend_nxt   = pend_r;
    go_nxt     = 1'b0;
    bwr_nxt    = bwr_r;
    badr_nxt   = badr_r;
    bdat_nxt   = bdat_r;
    cnt_nxt    = cnt_r;
    idx_nxt    = idx_r;
    addr_nxt   = addr_r;
    data_nxt   = data_r;
    count_nxt  = count_r;
    ready_nxt  = ready_r;
    done_nxt   = 1'b0;
    rd_nxt     = rd_r;
    err_nxt    = err_r;
    rp_n_nxt   = rp_n_r;
    hh_nxt     = hh_r;
    program_enable_supply_nxt   = program_enable_supply_r;
    req        = 1'b0;
    req_wr     = 1'b1;
    req_adr    = addr_r;
    req_dat    = {`FCI_CMD_UPPER, first_code(op_r)};
    fin        = pend_r && bus_done;
    case (st_r)
      FCI_ST_RST_HOLD:
      begin
        rp_n_nxt = 1'b0;
        cnt_nxt  = cnt_r + 8'h01;
        if (cnt_r == `FCI_RP_CYC - 8'h01)
        begin
          cnt_nxt  = 8'h00;
          rp_n_nxt = 1'b1;
          st_nxt   = FCI_ST_RST_WAIT;
        end
      end
      FCI_ST_RST_WAIT:
      begin
        cnt_nxt = cnt_r + 8'h01;
        // Flash wakes in array read mode, no command needed
        if (cnt_r == `FCI_RECOVER_CYC - 8'h01)
        begin
          ready_nxt = 1'b1;
          st_nxt    = FCI_ST_IDLE;
        end
      end
      FCI_ST_IDLE:
        if (cmd_valid && ready_r)
        begin
          op_nxt    = cmd_op;
          addr_nxt  = cmd_addr;
          data_nxt  = cmd_data;
          count_nxt = cmd_count;
          idx_nxt   = 5'h00;
          ready_nxt = 1'b0;
          // Supply raised for altering operations and for suspend and resume, not for reads or config
          program_enable_supply_nxt  = cmd_op >= FCI_OP_BUFFER && cmd_op != FCI_OP_CONFIG;
          // Elevated reset level for locked targets, always for master lock
          hh_nxt    = cmd_elevate || cmd_op == FCI_OP_SET_MASTER_LOCK;
          st_nxt    = cmd_op == FCI_OP_READ ? FCI_ST_READ : FCI_ST_CMD1;
        end
      FCI_ST_CMD1:
      begin
        req = 1'b1;
        if (fin)
          case (op_r)
            FCI_OP_READ_ID, FCI_OP_READ_QUERY, FCI_OP_READ_STATUS: st_nxt = FCI_ST_READ;
            FCI_OP_BUFFER:  st_nxt = FCI_ST_XSR;
            FCI_OP_SUSPEND: st_nxt = FCI_ST_POLL;
            FCI_OP_READ_ARRAY, FCI_OP_CLEAR_STATUS, FCI_OP_RESUME: st_nxt = FCI_ST_FINISH;
            default:        st_nxt = FCI_ST_CMD2;
          endcase
      end
      FCI_ST_CMD2:
      begin
        req     = 1'b1;
        req_dat = second_word(op_r, data_r);
        if (fin)
          st_nxt = op_r == FCI_OP_CONFIG ? FCI_ST_FINISH : FCI_ST_POLL;
      end
      FCI_ST_READ:
      begin
        req    = 1'b1;
        req_wr = 1'b0;
        if (fin)
        begin
          rd_nxt = bus_rdata;
          st_nxt = FCI_ST_FINISH;
        end
      end
      FCI_ST_XSR:
      begin
        req    = 1'b1;
        req_wr = 1'b0;
        // No free buffer: repeat the setup write and check again
        if (fin)
          st_nxt = bus_rdata[`FCI_XSR_AVAIL_BIT] ? FCI_ST_COUNT : FCI_ST_CMD1;
      end
      FCI_ST_COUNT:
      begin
        req     = 1'b1;
        req_dat = {`FCI_CMD_UPPER, 3'b000, count_r};
        if (fin)
          st_nxt = FCI_ST_DATA;
      end
      FCI_ST_DATA:
      begin
        if (!pend_r && buf_valid && bufrdy_r)
        begin
          go_nxt   = 1'b1;
          pend_nxt = 1'b1;
          bwr_nxt  = 1'b1;
          badr_nxt = addr_r + {18'h00000, idx_r};
          bdat_nxt = buf_data;
        end
        if (fin)
        begin
          pend_nxt = 1'b0;
          idx_nxt  = idx_r + 5'h01;
          // Exactly N+1 words, then straight to confirm
          if (idx_r == count_r)
            st_nxt = FCI_ST_CONFIRM;
        end
      end
      FCI_ST_CONFIRM:
      begin
        req     = 1'b1;
        req_dat = {`FCI_CMD_UPPER, `FCI_CMD_CONFIRM};
        if (fin)
          st_nxt = FCI_ST_POLL;
      end
      FCI_ST_POLL:
      begin
        // Skip bus reads while the busy pin is still low
        req    = !sts_busy || pend_r;
        req_wr = 1'b0;
        if (fin && bus_rdata[`FCI_SR_READY_BIT])
        begin
          rd_nxt  = bus_rdata;
          err_nxt = |(bus_rdata[7:0] & `FCI_SR_ERR_MASK);
          st_nxt  = FCI_ST_FINISH;
        end
      end
      FCI_ST_FINISH:
      begin
        done_nxt  = 1'b1;
        hh_nxt    = 1'b0;
        program_enable_supply_nxt  = 1'b0;
        ready_nxt = 1'b1;
        st_nxt    = FCI_ST_IDLE;
      end
      default:
        st_nxt = FCI_ST_RST_HOLD;
    endcase
    // Common launch and completion of a single bus cycle
    if (req && !pend_r)
    begin
      go_nxt   = 1'b1;
      pend_nxt = 1'b1;
      bwr_nxt  = req_wr;
      badr_nxt = req_adr;
      bdat_nxt = req_dat;
    end
    if (fin)
      pend_nxt = 1'b0;
    bufrdy_nxt = st_nxt == FCI_ST_DATA && !pend_nxt;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st_r <= FCI_ST_RST_HOLD;
      op_r <= FCI_OP_READ;
      pend_r <= 1'b0;
      go_r <= 1'b0;
      bwr_r <= 1'b0;
      badr_r <= 23'h000000;
      bdat_r <= 16'h0000;
      cnt_r <= 8'h00;
      idx_r <= 5'h00;
      addr_r <= 23'h000000;
      data_r <= 16'h0000;
      count_r <= 5'h00;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      rd_r <= 16'h0000;
      err_r <= 1'b0;
      bufrdy_r <= 1'b0;
      rp_n_r <= 1'b0;
      hh_r <= 1'b0;
      program_enable_supply_r <= 1'b0;
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      busy_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      pend_r <= pend_nxt;
      go_r <= go_nxt;
      bwr_r <= bwr_nxt;
      badr_r <= badr_nxt;
      bdat_r <= bdat_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      count_r <= count_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rd_r <= rd_nxt;
      err_r <= err_nxt;
      bufrdy_r <= bufrdy_nxt;
      rp_n_r <= rp_n_nxt;
      hh_r <= hh_nxt;
      program_enable_supply_r <= program_enable_supply_nxt;
      s1_r <= flash_sts_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Busy level changes only once the last two stages agree
      if (s2_r == s3_r)
        busy_r <= ~s3_r;
    end
  end

  assign cmd_ready      = ready_r;
  assign done           = done_r;
  assign rd_data        = rd_r;
  assign status_err     = err_r;
  assign sts_busy       = busy_r;
  assign buf_ready      = bufrdy_r;
  assign flash_rp_n     = rp_n_r;
  assign flash_rp_hh_en = hh_r;
  assign flash_program_enable_supply_en  = program_enable_supply_r;

  // ----------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------
  fci_bus_cycle u_bus (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .go          (go_r),
    .wr          (bwr_r),
    .addr        (badr_r),
    .wdata       (bdat_r),
    .done        (bus_done),
    .rdata       (bus_rdata),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n)
  );

endmodule

// File: testbench/fci_flash_model.sv
// Behavioural flash device on the host pins.
// Decodes writes on the rising write strobe; no timing checks.
`timescale 1ns/1ns
module fci_flash_model #(
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary
  parameter logic [7:0] DEV_ID = 8'h3c  // Arbitrary
) (
  // Pins
  input wire logic [22:0] a,
  input wire logic [15:0] d,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        rp_n,
  input wire logic        hh,
  input wire logic        program_enable_supply,
  output logic     [15:0] q,
  output logic            sts
);
  logic [15:0] mem [logic [22:0]];
  logic [63:0] lk = '0;
  logic [15:0] rdv;
  logic [15:0] last = '0;
  logic [7:0]  sr, pend, p, c, cfg;
  logic [2:0]  md;
  logic [5:0]  cnt;
  logic        bsy, g;
  logic        mlk = 1'b0;
  // Locked blocks need the elevated level; low supply blocks all
  function automatic logic ok(input logic [22:0] x);
    return program_enable_supply && (!lk[x[22:17]] || hh);
  endfunction
  // Errors stay sticky until cleared
  task automatic run(input logic k, input logic [7:0] e);
    sr = sr | (k ? 8'h00 : e);
    md = 3'd3;
    bsy = k;
    if (k)
      fork
        #400 bsy = 1'b0;
      join_none
  endtask
  // ----
  // Command decode
  // ----
  always @(posedge we_n)
  begin
    c = d[7:0];
    p = pend;
    if (!ce_n && rp_n)
    begin
      pend = 8'h00;
      case (p)
        8'h40: begin if (ok(a)) mem[a] = d; run(ok(a), 8'h12); end
        8'h20, 8'hea: run(c == 8'hd0 && ok(a), 8'h32);
        8'he8: begin cnt = {1'b0, d[4:0]}; pend = 8'he9; end
        8'he9: begin mem[a] = d; pend = (cnt == 0) ? 8'hea : 8'he9; cnt--; end
        8'hb8: cfg = c;
        8'h60:
        begin
          g = program_enable_supply && (c == 8'hf1 ? hh : (!mlk || hh));
          if (g && c == 8'h01) lk[a[22:17]] = 1'b1;
          if (g && c == 8'hf1) mlk = 1'b1;
          if (g && c == 8'hd0) lk = '0;
          run(g, 8'h12);
        end
        default:
          case (c)
            8'hff: if (!bsy) md = 3'd0;
            8'h90: md = 3'd1;
            8'h98: md = 3'd2;
            8'h70: md = 3'd3;
            8'h50: sr = 8'h00;
            8'hb0: bsy = 1'b0;
            8'hd0: run(1'b1, 8'h00);
            default: begin pend = (c == 8'h10) ? 8'h40 : c; md = (c == 8'he8) ? 3'd4 : 3'd3; end
          endcase
      endcase
    end
  end
  // Reset pin returns to array reads
  always @(negedge rp_n)
  begin
    md = 3'd0;
    pend = 8'h00;
    bsy = 1'b0;
    sr = 8'h00;
  end
  // Read data by mode; busy status floats all but bit 7
  always @*
    case (md)
      3'd0: rdv = mem.exists(a) ? mem[a] : a[15:0];
      3'd1: rdv = {8'h00, a[1:0] == 0 ? MFR_ID : a[1:0] == 1 ? DEV_ID : {7'h00, a[0] ? mlk : lk[a[22:17]]}};
      3'd2: rdv = bsy ? ~last : 16'h0051;
      3'd3: rdv = bsy ? {~last[15:8], 1'b0, ~last[6:0]} : {8'h00, 1'b1, sr[6:0]};
      default: rdv = 16'h0080;
    endcase
  // Released bus shows no stale value
  always @(posedge oe_n) last = rdv;
  assign q = (!ce_n && !oe_n && rp_n) ? rdv : ~last;
  assign sts = !rp_n || !bsy;
endmodule

// File: testbench/fci_host_bench.sv
// Self-checking bench for the flash host controller.
// Drives the user port at falling edges; the flash model sits on the pins.
`timescale 1ns/1ns
module fci_host_bench
  import fci_pkg::*;
;
  localparam logic [7:0] MFR = 8'h5a; // Arbitrary
  localparam logic [7:0] DEV = 8'h3c; // Arbitrary
  logic        core_clk = 0, rst_b = 0, cmd_valid = 0, cmd_elevate = 0, buf_valid = 0;
  fci_op_t     cmd_op = FCI_OP_READ;
  logic [22:0] cmd_addr = '0, flash_addr;
  logic [15:0] cmd_data = '0, buf_data = 16'h0a00, rd_data, flash_dq_o, flash_dq_i, mq;
  logic [4:0]  cmd_count = 5'h01;
  logic        cmd_ready, done, status_err, sts_busy, buf_ready, flash_dq_oe, flash_ce_n, flash_oe_n;
  logic        flash_we_n, flash_rp_n, flash_rp_hh_en, flash_program_enable_supply_en, flash_sts_i;
  int          n_fail = 0, checks = 0, cyc = 0;
  // Shared data wire: host wins while enabled
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : mq;
  fci_host dut (.core_clk, .rst_b, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_count, .cmd_elevate,
    .cmd_ready, .done, .rd_data, .status_err, .sts_busy, .buf_valid, .buf_data, .buf_ready, .flash_addr,
    .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rp_n,
    .flash_rp_hh_en, .flash_program_enable_supply_en, .flash_sts_i);
  fci_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) flash (.a(flash_addr), .d(flash_dq_i), .ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .rp_n(flash_rp_n), .hh(flash_rp_hh_en), .program_enable_supply(flash_program_enable_supply_en),
    .q(mq), .sts(flash_sts_i));
  always #4 core_clk = ~core_clk;
  // Buffer words count up; hang guard
  always @(posedge core_clk)
  begin
    if (buf_valid && buf_ready) buf_data <= buf_data + 16'h0001;
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      summarize();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One operation; s picks status_err over rd_data
  task automatic op(input fci_op_t o, input logic [22:0] a, input logic [15:0] d, input logic e, s,
                    input logic [15:0] x);
    logic [15:0] g;
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    cmd_op = o;
    cmd_addr = a;
    cmd_data = d;
    cmd_elevate = e;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1) @(negedge core_clk);
    g = s ? {15'h0000, status_err} : rd_data;
    checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("[ERR] %0t op %0d got %h exp %h", $time, o, g, x);
    end
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    buf_valid = 1'b1;
    op(FCI_OP_READ, 23'h000123, 16'h0000, 0, 0, 16'h0123);
    op(FCI_OP_READ_ID, 23'h000000, 16'h0000, 0, 0, {8'h00, MFR});
    op(FCI_OP_READ_ID, 23'h000001, 16'h0000, 0, 0, {8'h00, DEV});
    op(FCI_OP_READ_QUERY, 23'h000010, 16'h0000, 0, 0, 16'h0051);
    op(FCI_OP_READ_STATUS, 23'h000000, 16'h0000, 0, 0, 16'h0080);
    $display("test reads done");
    op(FCI_OP_PROGRAM, 23'h000040, 16'hbeef, 0, 1, 16'h0000);
    op(FCI_OP_READ_ARRAY, 23'h000000, 16'h0000, 0, 1, 16'h0000);
    op(FCI_OP_READ, 23'h000040, 16'h0000, 0, 0, 16'hbeef);
    $display("test program done");
    op(FCI_OP_SET_BLOCK_LOCK, 23'h020000, 16'h0000, 0, 1, 16'h0000);
    op(FCI_OP_READ_ID, 23'h020002, 16'h0000, 0, 0, 16'h0001);
    op(FCI_OP_PROGRAM, 23'h020004, 16'h1234, 0, 1, 16'h0001);
    op(FCI_OP_CLEAR_STATUS, 23'h000000, 16'h0000, 0, 1, 16'h0001);
    op(FCI_OP_READ_STATUS, 23'h000000, 16'h0000, 0, 0, 16'h0080);
    op(FCI_OP_PROGRAM, 23'h020004, 16'h1234, 1, 1, 16'h0000);
    $display("test locks done");
    op(FCI_OP_BUFFER, 23'h000100, 16'h0000, 0, 1, 16'h0000);
    op(FCI_OP_READ_ARRAY, 23'h000000, 16'h0000, 0, 1, 16'h0000);
    op(FCI_OP_READ, 23'h000101, 16'h0000, 0, 0, 16'h0a01);
    $display("test buffer done");
    op(FCI_OP_ERASE, 23'h020000, 16'h0000, 1, 1, 16'h0000);
    op(FCI_OP_CLEAR_LOCKS, 23'h000000, 16'h0000, 0, 1, 16'h0000);
    op(FCI_OP_SET_MASTER_LOCK, 23'h000000, 16'h0000, 0, 1, 16'h0000);
    op(FCI_OP_SET_BLOCK_LOCK, 23'h040000, 16'h0000, 0, 1, 16'h0001);
    op(FCI_OP_CLEAR_STATUS, 23'h000000, 16'h0000, 0, 1, 16'h0001);
    op(FCI_OP_RESUME, 23'h000000, 16'h0000, 0, 1, 16'h0001);
    op(FCI_OP_READ_ARRAY, 23'h000000, 16'h0000, 0, 1, 16'h0001);
    op(FCI_OP_SUSPEND, 23'h000000, 16'h0000, 0, 1, 16'h0000);
    $display("test erase done");
    summarize();
  end
endmodule

// File: testbench/fci_host_checker.sv
// Pin and user-port assertions for the flash host.
// Bound into fci_host; one clock domain.
`timescale 1ns/1ns
module fci_host_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // User side
  input wire logic        cmd_ready,
  input wire logic        done,
  input wire logic        sts_busy,
  // Flash pins
  input wire logic [22:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        flash_rp_n,
  input wire logic        flash_sts_i
);
  // ----
  // Properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  rp_low_hold_a: assert property ($rose(rst_b) |-> !flash_rp_n [*8])
    else $error("reset pin released early");
  done_pulse_a: assert property (done |-> cmd_ready ##1 !done)
    else $error("done not a pulse");
  idle_quiet_a: assert property (cmd_ready |-> flash_ce_n && flash_we_n && flash_oe_n)
    else $error("bus active while idle");
  strobe_excl_a: assert property (!(flash_oe_n == 1'b0 && flash_we_n == 1'b0))
    else $error("read and write strobes together");
  read_float_a: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives data during read");
  we_width_a: assert property ($fell(flash_we_n) |-> !flash_ce_n && !flash_we_n [*8])
    else $error("write pulse too short");
  wdata_stable_a: assert property (!flash_we_n |=> $stable(flash_dq_o) && $stable(flash_addr))
    else $error("data moved under write strobe");
  busy_sync_a: assert property ($fell(flash_sts_i) ##1 !flash_sts_i [*4] |-> sts_busy)
    else $error("busy pin not followed");
  // Main scenarios reached
  cover property ($fell(flash_we_n));
  cover property (done);
  cover property (sts_busy);
endmodule
bind fci_host fci_host_checker u_chk (.core_clk, .rst_b, .cmd_ready, .done, .sts_busy, .flash_addr,
  .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rp_n, .flash_sts_i);
